// ==== core/mdsi_pkg.sv ====
// constants, enumerations and carriers for the modem serial data interchange
`default_nettype none
package mdsi_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] div_off = 8'h04;
  localparam logic [7:0] stat_off = 8'h08;
  // reset values and the word transfer size
  localparam logic [7:0] ctrl_rst = 8'h01;
  localparam logic [15:0] div_rst = 16'h0007;
  localparam logic [2:0] hsize_word = 3'h2;
  // status field positions and receive buffer depth
  localparam int stat_carrier_pos = 0;
  localparam int stat_trained_pos = 1;
  localparam int stat_full_pos = 2;
  localparam int stat_empty_pos = 3;
  localparam int stat_line_pos = 4;
  localparam int stat_txbit_pos = 5;
  localparam logic [1:0] fifo_depth = 2'h2;

  typedef enum logic [1:0] {mdsi_full, mdsi_rx_only, mdsi_tx_only} mdsi_variant_type;
  typedef enum logic [1:0] {mdsi_lv2, mdsi_lv4, mdsi_lv8} mdsi_level_type;

  // control word, low bit first: enable, unclamp, level, idle_alt, ext_sel, variant
  typedef struct packed {
    mdsi_variant_type variant;
    logic ext_sel;
    logic idle_alt;
    mdsi_level_type level;
    logic unclamp;
    logic enable;
  } mdsi_ctrl_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wr_pend;
    logic [7:0] waddr;
    mdsi_ctrl_type ctrl;
    logic [15:0] div;
    logic [15:0] cnt;
    logic bclk;
    logic tclk;
    logic [1:0] xs;
    logic xprev;
    logic [1:0] ds;
    logic [1:0] fifo;
    logic [1:0] fcnt;
    logic in_ready;
    logic rx_line;
    logic carrier;
    logic [1:0] pat;
    logic tx_valid;
    logic tx_bit;
  } mdsi_state_type;
endpackage
`default_nettype wire

// ==== core/mdsi_top.sv ====
// data set end of the synchronous serial data interchange, with an AHB-Lite register slave
// What this block does
// - line bit 1 is mark, 0 is space
// - receive data changes on receive clock rise
// - clamped: receive data mark without carrier
// - unclamped: data valid only with carrier
// - 2-level idle: steady 0 or 1
// - 4-level idle: dotting or steady 1
// - 8-level idle: repeating 010 or 110
// - receive-only: no send data, no tx clock
// - transmit-only: receive data held at mark
// - control lead high means ON
// - carrier ON only after receiver trained
`default_nettype none
module mdsi_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic send_serial_line,
  input wire logic external_transmit_bit_clock,
  output logic internal_transmit_bit_clock,
  output logic receive_bit_clock,
  output logic receive_serial_line,
  output logic carrier_present_line,
  input wire logic rx_in_valid,
  input wire logic rx_in_bit,
  output logic rx_in_ready,
  input wire logic trained_in,
  input wire logic signal_in,
  output logic tx_out_valid,
  output logic tx_out_bit
);
  mdsi_pkg::mdsi_state_type st;
  mdsi_pkg::mdsi_state_type next_st;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic acc;
    logic tick;
    logic rise;
    logic fall;
    logic pop;
    logic push;
    logic idle_bit;
    logic [1:0] cnt_after;
    acc = 1'b0;
    tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    idle_bit = 1'b1;
    cnt_after = 2'h0;
    next_st = st;
    if (ce)
    begin
      // bus slave: zero wait states, read data loaded at the address phase
      next_st.hreadyout = 1'b1;
      next_st.hresp = 1'b0;
      next_st.wr_pend = 1'b0;
      acc = hsel && hready && htrans[1] && hsize == mdsi_pkg::hsize_word;
      if (st.wr_pend)
      begin
        if (st.waddr == mdsi_pkg::ctrl_off)
        begin
          next_st.ctrl = mdsi_pkg::mdsi_ctrl_type'(hwdata[7:0]);
        end
        else if (st.waddr == mdsi_pkg::div_off)
        begin
          next_st.div = hwdata[15:0];
        end
      end
      if (acc && hwrite)
      begin
        next_st.wr_pend = 1'b1;
        next_st.waddr = haddr[7:0];
      end
      if (acc && !hwrite)
      begin
        next_st.hrdata = 32'h0000_0000;
        if (haddr[7:0] == mdsi_pkg::ctrl_off)
        begin
          next_st.hrdata[7:0] = st.ctrl;
        end
        else if (haddr[7:0] == mdsi_pkg::div_off)
        begin
          next_st.hrdata[15:0] = st.div;
        end
        else if (haddr[7:0] == mdsi_pkg::stat_off)
        begin
          next_st.hrdata[mdsi_pkg::stat_carrier_pos] = st.carrier;
          next_st.hrdata[mdsi_pkg::stat_trained_pos] = trained_in;
          next_st.hrdata[mdsi_pkg::stat_full_pos] = st.fcnt == mdsi_pkg::fifo_depth;
          next_st.hrdata[mdsi_pkg::stat_empty_pos] = st.fcnt == 2'h0;
          next_st.hrdata[mdsi_pkg::stat_line_pos] = st.rx_line;
          next_st.hrdata[mdsi_pkg::stat_txbit_pos] = st.tx_bit;
        end
      end

      // bit clock divider, shared by receive and internal transmit clocks
      if (st.ctrl.enable)
      begin
        if (st.cnt >= st.div)
        begin
          next_st.cnt = 16'h0000;
          tick = 1'b1;
        end
        else
        begin
          next_st.cnt = st.cnt + 16'h0001;
        end
      end
      else
      begin
        next_st.cnt = 16'h0000;
        next_st.bclk = 1'b0;
      end
      if (tick)
      begin
        next_st.bclk = !st.bclk;
      end
      rise = tick && !st.bclk;
      // receive-only sets drive no transmit clock; kept in a flop so the pin is glitch free
      next_st.tclk = next_st.bclk && next_st.ctrl.variant != mdsi_pkg::mdsi_rx_only;

      // pin synchronisers; nothing but the second stage reads the first
      next_st.xs = {st.xs[0], external_transmit_bit_clock};
      next_st.ds = {st.ds[0], send_serial_line};
      next_st.xprev = st.xs[1];

      // send data sampled mid-bit, on the falling edge of the chosen clock
      fall = st.ctrl.ext_sel ? (st.xprev && !st.xs[1]) : (tick && st.bclk);
      next_st.tx_valid = 1'b0;
      if (fall && st.ctrl.enable && st.ctrl.variant != mdsi_pkg::mdsi_rx_only)
      begin
        next_st.tx_valid = 1'b1;
        next_st.tx_bit = st.ds[1];
      end

      // carrier follows training and signal, while enabled and not transmit-only
      next_st.carrier = st.ctrl.enable && st.ctrl.variant != mdsi_pkg::mdsi_tx_only
        && trained_in && signal_in;

      // idle pattern with carrier off and the line unclamped
      unique case (st.ctrl.level)
        mdsi_pkg::mdsi_lv2: idle_bit = st.ctrl.idle_alt;
        mdsi_pkg::mdsi_lv4: idle_bit = st.ctrl.idle_alt ? !st.rx_line : 1'b1;
        mdsi_pkg::mdsi_lv8: idle_bit = st.pat == 2'h1 || (st.pat == 2'h0 && st.ctrl.idle_alt);
        default: idle_bit = 1'b1;
      endcase

      // two-entry receive buffer, drained once per receive clock period
      pop = rise && st.carrier && st.fcnt != 2'h0 && st.ctrl.variant != mdsi_pkg::mdsi_tx_only;
      push = rx_in_valid && st.in_ready;
      cnt_after = st.fcnt;
      if (pop)
      begin
        next_st.fifo[0] = st.fifo[1];
        cnt_after = st.fcnt - 2'h1;
      end
      if (push)
      begin
        next_st.fifo[cnt_after[0]] = rx_in_bit;
        cnt_after = cnt_after + 2'h1;
      end
      next_st.fcnt = cnt_after;
      next_st.in_ready = cnt_after != mdsi_pkg::fifo_depth;

      // receive line moves only on the receive clock rise
      if (rise)
      begin
        next_st.pat = st.pat == 2'h2 ? 2'h0 : st.pat + 2'h1;
        if (st.ctrl.variant == mdsi_pkg::mdsi_tx_only)
        begin
          next_st.rx_line = 1'b1;
        end
        else if (!st.carrier)
        begin
          next_st.rx_line = st.ctrl.unclamp ? idle_bit : 1'b1;
        end
        else
        begin
          // an empty buffer under carrier sends mark rather than stale data
          next_st.rx_line = pop ? st.fifo[0] : 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.ctrl <= mdsi_pkg::mdsi_ctrl_type'(mdsi_pkg::ctrl_rst);
      st.div <= mdsi_pkg::div_rst;
      st.rx_line <= 1'b1;
      st.tx_bit <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign receive_bit_clock = st.bclk;
  assign internal_transmit_bit_clock = st.tclk;
  assign receive_serial_line = st.rx_line;
  assign carrier_present_line = st.carrier;
  assign rx_in_ready = st.in_ready;
  assign tx_out_valid = st.tx_valid;
  assign tx_out_bit = st.tx_bit;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_rx_rise;
    $rose(st.bclk);
  endsequence
  sequence s_idle(mdsi_pkg::mdsi_level_type lv);
    s_rx_rise ##0 ($past(!st.carrier && st.ctrl.unclamp && st.ctrl.level == lv
      && st.ctrl.variant != mdsi_pkg::mdsi_tx_only));
  endsequence

  property p_line_on_rise;
    $changed(st.rx_line) |-> st.bclk && !$past(st.bclk);
  endproperty
  a_line_on_rise: assert property (p_line_on_rise) else $error("receive line moved off clock rise");

  property p_clamp;
    s_rx_rise ##0 $past(!st.carrier && !st.ctrl.unclamp) |-> st.rx_line;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamped line not at mark");

  property p_txonly_mark;
    s_rx_rise ##0 $past(st.ctrl.variant == mdsi_pkg::mdsi_tx_only) |-> st.rx_line;
  endproperty
  a_txonly_mark: assert property (p_txonly_mark) else $error("transmit-only line not at mark");

  property p_rxonly_quiet;
    $past(ce && st.ctrl.variant == mdsi_pkg::mdsi_rx_only) |-> !st.tx_valid;
  endproperty
  a_rxonly_quiet: assert property (p_rxonly_quiet) else $error("receive-only set took send data");

  property p_carrier_trained;
    $rose(st.carrier) |-> $past(trained_in && signal_in);
  endproperty
  a_carrier_trained: assert property (p_carrier_trained) else $error("carrier rose untrained");

  property p_idle2;
    s_idle(mdsi_pkg::mdsi_lv2) |-> st.rx_line == $past(st.ctrl.idle_alt);
  endproperty
  a_idle2: assert property (p_idle2) else $error("2-level idle not steady");

  property p_idle4;
    s_idle(mdsi_pkg::mdsi_lv4) |-> st.rx_line == ($past(st.ctrl.idle_alt) ? !$past(st.rx_line) : 1'b1);
  endproperty
  a_idle4: assert property (p_idle4) else $error("4-level idle pattern wrong");

  property p_idle8;
    s_idle(mdsi_pkg::mdsi_lv8) |-> st.rx_line == ($past(st.pat) == 2'h1
      || ($past(st.pat) == 2'h0 && $past(st.ctrl.idle_alt)));
  endproperty
  a_idle8: assert property (p_idle8) else $error("8-level idle pattern wrong");

  property p_ext_sample;
    $past(ce && st.ctrl.enable && st.ctrl.ext_sel && st.xprev && !st.xs[1]
      && st.ctrl.variant != mdsi_pkg::mdsi_rx_only) |-> st.tx_valid && st.tx_bit == $past(st.ds[1]);
  endproperty
  a_ext_sample: assert property (p_ext_sample) else $error("external clock fall not sampled");

  property p_ahb_okay;
    (ce && hsel && hready && htrans[1]) |=> st.hreadyout && !st.hresp;
  endproperty
  a_ahb_okay: assert property (p_ahb_okay) else $error("bus answer not ready okay");
endmodule
`default_nettype wire

// ==== test/mdsi_bm_model.sv ====
// business machine model driving send data on the chosen bit clock
`default_nettype none
module mdsi_bm_model (
  input wire logic use_ext,
  input wire logic int_clk,
  input wire logic ext_run,
  input wire logic go,
  input wire logic [15:0] frame,
  output logic ext_clk,
  output logic send_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt = 5'h00;
  logic bclk;
  logic ec = 1'b0;
  logic sl = 1'b1;
  assign ext_clk = ec;
  assign send_line = sl;
  // ----
  // own clock stands still low while ext_run is low
  // ----
  always #62.5 ec = ext_run & ~ec;
  assign bclk = use_ext ? ec : int_clk;
  always @(posedge bclk)
  begin
    if (go && cnt < 5'h10)
    begin
      sl <= frame[cnt[3:0]];
      cnt <= cnt + 5'h01;
    end
    else
    begin
      sl <= 1'b1;
      if (!go)
        cnt <= 5'h00;
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the modem serial data interchange
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // stimulus, model and monitor
  // ----
  logic clk_sys = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rxv = 1'b0, rxb = 1'b0, trn = 1'b0, sig = 1'b0;
  logic use_ext = 1'b0, ext_run = 1'b0, go = 1'b0, pr = 1'b0, pl = 1'b1, ce = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [7:0] ha = 8'h00;
  logic [31:0] hwdata = 32'h0, seed = 32'h82ca18e7, rd, hrdata;
  logic [15:0] frame = 16'h0;
  logic hreadyout, hresp, sd, ext_clk, itc, rbc, rsl, cp, rxr, txv, txb;
  int n_errors = 0, checks_done = 0, nq = 0;
  logic q[$];
  logic tq[$];
  always #2 clk_sys = ~clk_sys;
  mdsi_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr({24'h0, ha}), .htrans(htrans),
    .hwrite(hwrite), .hsize(mdsi_pkg::hsize_word), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .send_serial_line(sd), .external_transmit_bit_clock(ext_clk),
    .internal_transmit_bit_clock(itc), .receive_bit_clock(rbc), .receive_serial_line(rsl),
    .carrier_present_line(cp), .rx_in_valid(rxv), .rx_in_bit(rxb), .rx_in_ready(rxr), .trained_in(trn),
    .signal_in(sig), .tx_out_valid(txv), .tx_out_bit(txb));
  mdsi_bm_model bm_u (.use_ext(use_ext), .int_clk(itc), .ext_run(ext_run), .go(go), .frame(frame),
    .ext_clk(ext_clk), .send_line(sd));
  always @(posedge clk_sys)
  begin
    if (rstn && rbc === 1'b1 && pr === 1'b0)
      q.push_back(rsl);
    else if (rstn && rsl !== pl)
      chk("line off clock rise", 1'b0, 1'b1);
    if (txv === 1'b1)
      tq.push_back(txb);
    pr <= rbc;
    pl <= rsl;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waits are ended only by the watchdog
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    ha <= a;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("bus answer", 32'h0, {31'h0, hresp});
  endtask
  task automatic push(input logic b);
    rxv <= 1'b1;
    rxb <= b;
    do @(posedge clk_sys); while (rxr !== 1'b1);
  endtask
  // first zero starts the stream, mark must follow it
  task automatic match(input string nm, ref logic s[$], input logic [15:0] e, input int n);
    int k;
    k = 0;
    while (k < s.size() && s[k] !== 1'b0)
      k++;
    for (int i = 0; i <= n; i++)
      chk(nm, (i < n) ? e[i] : 1'b1, (k + i < s.size()) ? s[k+i] : 1'bx);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic idle_ok(input int lv, input logic alt);
    logic ok;
    int k, ones;
    ok = q.size() >= 10;
    k = q.size() - 6;
    ones = 0;
    for (int i = k; i < k + 6; i++)
    begin
      if (i < k + 3)
        ones += int'(q[i] === 1'b1);
      case (lv)
        0: ok &= q[i] === alt;
        1: ok &= alt ? (i == k || q[i] !== q[i-1]) : q[i] === 1'b1;
        default: ok &= (i < k + 3 || q[i] === q[i-3]);
      endcase
    end
    if (lv == 2)
      ok &= ones == (alt ? 2 : 1);
    return ok;
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    bus(1'b0, mdsi_pkg::ctrl_off, 32'h0);
    chk("ctrl reset", {24'h0, mdsi_pkg::ctrl_rst}, rd);
    bus(1'b0, mdsi_pkg::div_off, 32'h0);
    chk("div reset", {16'h0, mdsi_pkg::div_rst}, rd);
    bus(1'b1, 8'h0c, 32'h5);
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, mdsi_pkg::div_off, 32'h5);
    bus(1'b0, mdsi_pkg::div_off, 32'h0);
    chk("div", 32'h5, rd);
    $display("done registers");
    seed = lfsr(seed);
    frame = {seed[15:1], 1'b0};
    trn <= 1'b1;
    push(frame[0]);
    push(frame[1]);
    rxv <= 1'b0;
    q.delete();
    repeat (64) @(posedge clk_sys);
    chk("ready when full", 32'h0, rxr);
    chk("carrier no signal", 32'h0, cp);
    foreach (q[i]) chk("clamped line", 32'h1, q[i]);
    bus(1'b0, mdsi_pkg::stat_off, 32'h0);
    chk("full flag", 32'h1, rd[mdsi_pkg::stat_full_pos]);
    trn <= 1'b0;
    sig <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("carrier untrained", 32'h0, cp);
    q.delete();
    trn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("carrier on", 32'h1, cp);
    for (int i = 2; i < 8; i++)
      push(frame[i]);
    rxv <= 1'b0;
    repeat (150) @(posedge clk_sys);
    match("receive stream", q, frame, 8);
    sig <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("carrier off", 32'h0, cp);
    $display("done receive");
    for (int lv = 0; lv < 3; lv++)
      for (int a = 0; a < 2; a++)
      begin
        bus(1'b1, mdsi_pkg::ctrl_off, 32'h3 | lv << 2 | a << 4);
        q.delete();
        repeat (130) @(posedge clk_sys);
        chk("idle pattern", 32'h1, idle_ok(lv, a[0]));
      end
    // clock enable low must stop the receive clock and line
    ce <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nq = q.size();
    repeat (50) @(posedge clk_sys);
    chk("frozen receive clock", nq, q.size());
    ce <= 1'b1;
    $display("done idle");
    bus(1'b1, mdsi_pkg::ctrl_off, 32'h97);
    sig <= 1'b1;
    // the rise at the write's own edge still uses the old control word
    repeat (2) @(posedge clk_sys);
    q.delete();
    repeat (100) @(posedge clk_sys);
    foreach (q[i]) chk("tx-only line", 32'h1, q[i]);
    sig <= 1'b0;
    bus(1'b1, mdsi_pkg::ctrl_off, 32'h41);
    repeat (2) @(posedge clk_sys);
    tq.delete();
    repeat (100) @(posedge clk_sys) chk("rx-only clock", 32'h0, itc);
    chk("rx-only samples", 32'h0, tq.size());
    $display("done variants");
    for (int x = 0; x < 2; x++)
    begin
      bus(1'b1, mdsi_pkg::ctrl_off, x ? 32'h21 : 32'h01);
      use_ext <= x[0];
      ext_run <= x[0];
      seed = lfsr(seed);
      frame <= {seed[15:1], 1'b0};
      tq.delete();
      go <= 1'b1;
      repeat (x ? 750 : 300) @(posedge clk_sys);
      go <= 1'b0;
      repeat (80) @(posedge clk_sys);
      ext_run <= 1'b0;
      match("send stream", tq, frame, 16);
    end
    $display("done transmit");
    finish_test;
  end
  initial
  begin
    #40000;
    n_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
